//--- core/spc2_consts.vh
`ifndef SPC2_CONSTS_VH
`define SPC2_CONSTS_VH
`define SPC2_OFF_DEV_CAP2 8'he4
`define SPC2_OFF_DEV_CTL2 8'he8
`define SPC2_OFF_LNK_CAP2 8'hec
`define SPC2_OFF_LNK_CTL2 8'hf0
`define SPC2_OFF_SLT_CAP2 8'hf4
`define SPC2_OFF_SLT_CTL2 8'hf8
`define SPC2_OFF_STRAP 8'hfc
`define SPC2_BIT_LTR_SUP 11
`define SPC2_BIT_FCU_LTR 12
`define SPC2_BIT_OBFF_SUP_LO 18
`define SPC2_BIT_LTR_EN 10
`define SPC2_BIT_OBFF_EN_LO 13
`define SPC2_BIT_SEL_DEEMP 6
`define SPC2_BIT_CUR_DEEMP 16
`define SPC2_RST_TGT_SPEED 4'h2
`define SPC2_RST_OBFF_SUP 2'h0
`define SPC2_RST_OBFF_EN 2'h0
`define SPC2_RST_MARGIN 3'h0
`define SPC2_LNK_CTL2_WMASK 16'h1fbf
`endif

//--- core/spc2_regs.v
`timescale 1ns/100ps
`include "spc2_consts.vh"
module spc2_regs #(
	parameter DOWNSTREAM = 1'b1
) (
	input wire clock_i,
	input wire srst_i,
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire strap_load_i,
	input wire strap_fcu_ltr_i,
	input wire [1:0] strap_obff_sup_i,
	input wire strap_sel_deemp_i,
	input wire deemp_update_i,
	input wire deemp_level_i,
	output wire ltr_enable_o,
	output wire [1:0] obff_enable_o,
	output wire [3:0] target_speed_o,
	output wire enter_compliance_o,
	output wire hardware_speed_change_disable_o,
	output wire select_deemp_o,
	output wire [2:0] margin_o,
	output wire enter_mod_compliance_o,
	output wire compliance_skip_sets_o,
	output wire compliance_deemp_o,
	output wire current_deemp_o
);
	localparam ST_IDLE = 1'b0;
	localparam ST_ACK = 1'b1;

	reg state_reg;
	reg fcu_ltr_reg;
	reg [1:0] obff_sup_reg;
	reg sel_deemp_reg;
	reg ltr_en_reg;
	reg [1:0] obff_en_reg;
	reg [3:0] tgt_speed_reg;
	reg enter_comp_reg;
	reg hw_speed_dis_reg;
	reg margin_lo_reg;
	reg [1:0] margin_hi_reg;
	reg mod_comp_reg;
	reg skip_sets_reg;
	reg comp_deemp_reg;
	reg cur_deemp_reg;
	reg [31:0] rd_next;
	reg [15:0] lnk_word;
	wire access;
	wire [7:0] word_addr;
	wire wr_done;
	wire wr_strap;
	wire wr_dev_ctl;
	wire wr_lnk_lo;
	wire wr_lnk_hi;

	// Same dword, whatever the byte offset
	function hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			hit = (addr[7:2] == offset[7:2]);
		end
	endfunction

	assign access = avs_read_i | avs_write_i;
	assign word_addr = {avs_address_i[7:2], 2'b00};
	// Writes land on the edge that ends the ST_ACK cycle, one cycle after the wait cycle
	assign wr_done = avs_write_i & (state_reg == ST_ACK);
	assign wr_strap = wr_done & hit(word_addr, `SPC2_OFF_STRAP) &
		avs_byteenable_i[0];
	assign wr_dev_ctl = wr_done & hit(word_addr, `SPC2_OFF_DEV_CTL2) &
		avs_byteenable_i[1];
	assign wr_lnk_lo = wr_done & hit(word_addr, `SPC2_OFF_LNK_CTL2) &
		avs_byteenable_i[0];
	assign wr_lnk_hi = wr_done & hit(word_addr, `SPC2_OFF_LNK_CTL2) &
		avs_byteenable_i[1];
	// One wait cycle, then the access completes
	assign avs_waitrequest_o = access & (state_reg == ST_IDLE);

	always @(posedge clock_i)
	begin
		if (srst_i)
			state_reg <= ST_IDLE;
		else
			case (state_reg)
				ST_IDLE: if (access) state_reg <= ST_ACK;
				ST_ACK: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
	end

	// Link control as software sees it; bit 6 is the strap select
	always @*
	begin
		lnk_word = 16'h0000;
		lnk_word[3:0] = tgt_speed_reg;
		lnk_word[4] = enter_comp_reg;
		lnk_word[5] = hw_speed_dis_reg;
		lnk_word[`SPC2_BIT_SEL_DEEMP] = sel_deemp_reg;
		lnk_word[9:7] = {margin_hi_reg, margin_lo_reg};
		lnk_word[10] = mod_comp_reg;
		lnk_word[11] = skip_sets_reg;
		lnk_word[12] = comp_deemp_reg;
	end

	// Strap values: the start-up loader beats a bus write
	always @(posedge clock_i)
	begin
		if (srst_i)
		begin
			fcu_ltr_reg <= 1'b0;
			obff_sup_reg <= `SPC2_RST_OBFF_SUP;
			sel_deemp_reg <= DOWNSTREAM;
		end
		else if (strap_load_i)
		begin
			fcu_ltr_reg <= strap_fcu_ltr_i;
			obff_sup_reg <= strap_obff_sup_i;
			sel_deemp_reg <= strap_sel_deemp_i;
		end
		else if (wr_strap)
		begin
			fcu_ltr_reg <= avs_writedata_i[0];
			obff_sup_reg <= avs_writedata_i[2:1];
			sel_deemp_reg <= avs_writedata_i[3];
		end
	end

	always @(posedge clock_i)
	begin
		if (srst_i)
		begin
			ltr_en_reg <= 1'b0;
			obff_en_reg <= `SPC2_RST_OBFF_EN;
		end
		else if (wr_dev_ctl)
		begin
			ltr_en_reg <= avs_writedata_i[`SPC2_BIT_LTR_EN];
			obff_en_reg <= avs_writedata_i[14:13];
		end
	end

	// Link control, low byte lane
	always @(posedge clock_i)
	begin
		if (srst_i)
		begin
			tgt_speed_reg <= `SPC2_RST_TGT_SPEED;
			enter_comp_reg <= 1'b0;
			hw_speed_dis_reg <= 1'b0;
			margin_lo_reg <= 1'b0;
		end
		else if (wr_lnk_lo)
		begin
			tgt_speed_reg <= avs_writedata_i[3:0];
			enter_comp_reg <= avs_writedata_i[4];
			hw_speed_dis_reg <= avs_writedata_i[5];
			margin_lo_reg <= avs_writedata_i[7];
		end
	end

	// Link control, high byte lane; bits 15:13 are not kept
	always @(posedge clock_i)
	begin
		if (srst_i)
		begin
			margin_hi_reg <= 2'b00;
			mod_comp_reg <= 1'b0;
			skip_sets_reg <= 1'b0;
			comp_deemp_reg <= 1'b0;
		end
		else if (wr_lnk_hi)
		begin
			margin_hi_reg <= avs_writedata_i[9:8];
			mod_comp_reg <= avs_writedata_i[10];
			skip_sets_reg <= avs_writedata_i[11];
			comp_deemp_reg <= avs_writedata_i[12];
		end
	end

	always @(posedge clock_i)
	begin
		if (srst_i)
			cur_deemp_reg <= DOWNSTREAM;
		else if (deemp_update_i)
			cur_deemp_reg <= deemp_level_i;
	end

	always @*
	begin
		rd_next = 32'h00000000;
		case (word_addr)
			`SPC2_OFF_DEV_CAP2:
			begin
				rd_next[`SPC2_BIT_LTR_SUP] = 1'b1;
				rd_next[`SPC2_BIT_FCU_LTR] = fcu_ltr_reg;
				rd_next[19:18] = obff_sup_reg;
			end
			`SPC2_OFF_DEV_CTL2:
			begin
				rd_next[`SPC2_BIT_LTR_EN] = ltr_en_reg;
				rd_next[14:13] = obff_en_reg;
			end
			`SPC2_OFF_LNK_CTL2:
			begin
				rd_next[15:0] = lnk_word;
				rd_next[`SPC2_BIT_CUR_DEEMP] = cur_deemp_reg;
			end
			`SPC2_OFF_STRAP:
				rd_next[3:0] = {sel_deemp_reg, obff_sup_reg, fcu_ltr_reg};
			default: rd_next = 32'h00000000;
		endcase
	end

	always @(posedge clock_i)
	begin
		if (srst_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && state_reg == ST_IDLE)
			avs_readdata_o <= rd_next;
	end

	assign ltr_enable_o = ltr_en_reg;
	assign obff_enable_o = obff_en_reg;
	assign target_speed_o = tgt_speed_reg;
	assign enter_compliance_o = enter_comp_reg;
	assign hardware_speed_change_disable_o = hw_speed_dis_reg;
	// Select only acts on downstream ports
	assign select_deemp_o = sel_deemp_reg & DOWNSTREAM;
	assign margin_o = {margin_hi_reg, margin_lo_reg};
	assign enter_mod_compliance_o = mod_comp_reg;
	assign compliance_skip_sets_o = skip_sets_reg;
	assign compliance_deemp_o = comp_deemp_reg;
	assign current_deemp_o = cur_deemp_reg;
endmodule

//--- sim/spc2_chk_assertions.sv
`timescale 1ns/100ps
module spc2_chk #(parameter DOWNSTREAM = 1'b1) (
	input clock_i, srst_i, avs_read_i, avs_write_i, avs_waitrequest_o,
	input strap_load_i, strap_sel_deemp_i, deemp_update_i, deemp_level_i,
	input ltr_enable_o, select_deemp_o, current_deemp_o,
	input [7:0] avs_address_i,
	input [31:0] avs_writedata_i, avs_readdata_o,
	input [3:0] avs_byteenable_i, target_speed_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	wire [31:0] q = avs_readdata_o;
	wire [7:0] a = avs_address_i;
	wire rdn = avs_read_i && !avs_waitrequest_o;
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	AST_ONE_WAIT:
	assert property ($rose(avs_read_i || avs_write_i) |->
		s_req ##1 !avs_waitrequest_o) else $error("wait");
	AST_CAP:
	assert property (rdn && a == 8'he4 |-> q[11] && (q & 32'hfff3e7ff) == 0)
		else $error("cap");
	AST_CTL:
	assert property (rdn && a == 8'he8 |->
		(q & 32'hffff9bff) == 0 && q[10] == ltr_enable_o) else $error("ctl");
	AST_WR:
	assert property (avs_write_i && !avs_waitrequest_o && a == 8'he8 &&
		avs_byteenable_i[1] |=> ltr_enable_o == $past(avs_writedata_i[10]))
		else $error("wr");
	AST_ZERO:
	assert property (rdn && (a == 8'hec || a == 8'hf4 || a == 8'hf8) |->
		q == 0) else $error("zero");
	AST_LNK:
	assert property (rdn && a == 8'hf0 |-> q[31:17] == 0 &&
		q[16] == current_deemp_o && (q[6] & DOWNSTREAM) == select_deemp_o)
		else $error("lnk");
	AST_SEL:
	assert property (select_deemp_o |-> DOWNSTREAM == 1) else $error("sel");
	AST_RST:
	assert property ($fell(srst_i) |-> select_deemp_o == DOWNSTREAM &&
		current_deemp_o == DOWNSTREAM && target_speed_o == 4'h2)
		else $error("rst");
	AST_STRAP:
	assert property (strap_load_i |=> select_deemp_o ==
		($past(strap_sel_deemp_i) && DOWNSTREAM)) else $error("strap");
	AST_DEEMP:
	assert property (deemp_update_i |=>
		current_deemp_o == $past(deemp_level_i)) else $error("deemp");
endmodule
bind spc2_regs spc2_chk #(.DOWNSTREAM(DOWNSTREAM)) u_chk (.*);

//--- sim/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %0t %h %h", $time, g, e); end end
module tb_top;
	reg clock_i = 0, srst_i = 1, rd = 0, wr = 0, ld = 0, f = 0, s = 0;
	reg u = 0, l = 0;
	reg [1:0] o = 0;
	reg [7:0] a = 0;
	reg [7:0] z [3] = '{8'hec, 8'hf4, 8'hf8};
	reg [31:0] wd = 0, q, q_up;
	wire [31:0] rdat, rdat_up;
	wire w, ltr, sel, cur, sel_up, cur_up, ec, hw, mc, ss, cd;
	wire [1:0] obff;
	wire [3:0] spd;
	wire [2:0] mg;
	int error_cnt = 0, checked = 0;
	spc2_regs DUT (.clock_i, .srst_i, .avs_address_i(a), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat), .avs_waitrequest_o(w), .strap_load_i(ld),
		.strap_fcu_ltr_i(f), .strap_obff_sup_i(o), .strap_sel_deemp_i(s),
		.deemp_update_i(u), .deemp_level_i(l), .ltr_enable_o(ltr),
		.obff_enable_o(obff), .target_speed_o(spd), .enter_compliance_o(ec),
		.hardware_speed_change_disable_o(hw), .select_deemp_o(sel),
		.margin_o(mg), .enter_mod_compliance_o(mc),
		.compliance_skip_sets_o(ss), .compliance_deemp_o(cd),
		.current_deemp_o(cur));
	spc2_regs #(.DOWNSTREAM(1'b0)) DUT_UP (.clock_i, .srst_i,
		.avs_address_i(a), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat_up), .avs_waitrequest_o(), .strap_load_i(ld),
		.strap_fcu_ltr_i(f), .strap_obff_sup_i(o), .strap_sel_deemp_i(s),
		.deemp_update_i(u), .deemp_level_i(l), .ltr_enable_o(),
		.obff_enable_o(), .target_speed_o(), .enter_compliance_o(),
		.hardware_speed_change_disable_o(), .select_deemp_o(sel_up),
		.margin_o(), .enter_mod_compliance_o(), .compliance_skip_sets_o(),
		.compliance_deemp_o(), .current_deemp_o(cur_up));
	task acc(input x, input [7:0] ad, input [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		{rd, wr} <= {!x, x};
		a <= ad;
		wd <= d;
		do @(posedge clock_i); while (w && n++ < 50);
		if (w) error_cnt++;
		q = rdat;
		q_up = rdat_up;
		rd <= 0;
		wr <= 0;
	endtask
	task rc(input [7:0] ad, input [31:0] e);
		acc(0, ad, 0);
		`CHK(q, e)
	endtask
	task complete_run;
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial forever #2.5 clock_i = ~clock_i;
	initial
	begin
		#20000 error_cnt++;
		complete_run;
	end
	initial
	begin
		repeat (12) @(posedge clock_i);
		srst_i <= 0;
		rc(8'he4, 32'h800);
		rc(8'he8, 0);
		rc(8'hf0, 32'h10042);
		`CHK(q_up, 32'h2)
		`CHK({sel, cur, sel_up, cur_up}, 4'hc)
		`CHK(spd, 4'h2)
		$display("reset test done");
		acc(1, 8'he8, '1);
		rc(8'he8, 32'h6400);
		`CHK({ltr, obff}, 3'h7)
		acc(1, 8'hf0, '1);
		rc(8'hf0, 32'h11fff);
		`CHK(q_up, 32'h1fbf)
		`CHK({cd, ss, mc, mg, hw, ec, spd}, 12'hfff)
		foreach (z[i])
		begin
			acc(1, z[i], '1);
			rc(z[i], 0);
		end
		rc(8'h00, 0);
		$display("write test done");
		f <= 1;
		o <= 2'h3;
		s <= 1;
		ld <= 1;
		@(posedge clock_i);
		ld <= 0;
		rc(8'he4, 32'hc1800);
		rc(8'hf0, 32'h11fff);
		`CHK(q_up, 32'h1fff)
		`CHK({sel, sel_up}, 2'h2)
		u <= 1;
		@(posedge clock_i);
		u <= 0;
		rc(8'hf0, 32'h1fff);
		`CHK(cur, 0)
		$display("strap test done");
		complete_run;
	end
endmodule
